// ### pin_function_pkg.sv
/*
 * Holds the register map, field positions, write masks and reset values
 * of the five pin function select registers.
 * Assumes a byte-wide register port and a single system clock.
 */
// Notes on behaviour
// - P2.5 bit 7 routes LED segment 21 drive onto the pin.
// - P2.5 bit 4 makes the pin the two-way line of capture/compare channel 4.
// - P2.5 bit 3 gives the pin to the I2C master clock, open drain.
// - P2.5 bit 2 gives the pin to I2C slave 1 clock, open drain.
// - P2.5 bit 6 gives the pin to I2C slave 2 clock, open drain.
// - Bit 0 enables plain general I/O; every register resets to zero.
// - P2.6 bit 7 routes LED segment 20 drive onto the pin.
// - P2.6 bit 4 makes the pin the line of capture/compare channel 5.
// - P2.6 bit 3 makes the pin the SPI slave select input.
// - P2.7 bit 7 routes LED segment 19 drive onto the pin.
// - P2.7 bit 4 feeds the pin to timer 2 as external trigger.
// - P2.7 bit 3 makes the pin the two-way SPI clock line.
// - P3.0 bit 4 makes the pin the line of capture/compare channel 2.
// - P3.1 bit 4 makes the pin the line of capture/compare channel 3.
// - Bit 2 of P3.0 or P3.1 adds the pin to interrupt group 1.
// - Bit 1 of P3.0 or P3.1 adds the pin to interrupt group 0.
// - Several pins may feed one interrupt group at once.
// - One pin may feed both interrupt groups together.
package pin_function_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int          NUM_PINS     = 5;
    localparam logic [15:0] OFS_P2_5     = 16'hA075;
    localparam logic [15:0] OFS_P2_6     = 16'hA076;
    localparam logic [15:0] OFS_P2_7     = 16'hA077;
    localparam logic [15:0] OFS_P3_0     = 16'hA078;
    localparam logic [15:0] OFS_P3_1     = 16'hA079;
    localparam logic [7:0]  RESET_VALUE  = 8'h00;

    // Writable bits of each register, pin index 0 to 4.
    localparam logic [7:0]  MASK_P2_5    = 8'hFD;
    localparam logic [7:0]  MASK_P2_6    = 8'h99;
    localparam logic [7:0]  MASK_P2_7    = 8'h99;
    localparam logic [7:0]  MASK_P3_0    = 8'h97;
    localparam logic [7:0]  MASK_P3_1    = 8'h97;

    // Pin indices.
    localparam int          PIN_P2_5     = 0;
    localparam int          PIN_P2_6     = 1;
    localparam int          PIN_P2_7     = 2;
    localparam int          PIN_P3_0     = 3;
    localparam int          PIN_P3_1     = 4;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_LED_SEGMENT         = 7;
    localparam int BIT_SLAVE2_I2C_CLOCK    = 6;
    localparam int BIT_COMPLEMENTARY_PWM   = 5;
    localparam int BIT_CAPCOMP_LINE        = 4;
    localparam int BIT_MASTER_I2C_CLOCK    = 3;
    localparam int BIT_SPI_SLAVE_SELECT    = 3;
    localparam int BIT_SPI_CLOCK           = 3;
    localparam int BIT_TIMER2_TRIGGER      = 4;
    localparam int BIT_SLAVE1_I2C_CLOCK    = 2;
    localparam int BIT_PIN_IRQ_GROUP1      = 2;
    localparam int BIT_PIN_IRQ_GROUP0      = 1;
    localparam int BIT_GENERAL_IO          = 0;

    // Capture/compare port order: channels 2, 3, 4, 5.
    localparam int CC_CH2 = 0;
    localparam int CC_CH3 = 1;
    localparam int CC_CH4 = 2;
    localparam int CC_CH5 = 3;

endpackage

// ### pin_function_select.sv
/*
 * Function select registers and pad multiplexer for pins P2.5 to P3.1.
 * Assumes pad inputs are asynchronous and pass a two-stage synchroniser,
 * and that peripheral signals come from logic on i_sys_clk.
 * Writes are masked, so unused bits read zero; unmapped reads give zero.
 * A low clock enable freezes registers, synchroniser and pad drive.
 */
// Our own choice: the strobed register port.
`timescale 1ns/1ns
module pin_function_select #(
    parameter logic PWM_COMP_ROUTE = 1'b1
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_clk_en,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    input  wire logic [4:0]  i_pad_in,
    output logic      [4:0]  o_pad_out,
    output logic      [4:0]  o_pad_oe,
    input  wire logic [4:0]  i_gpio_out,
    input  wire logic [4:0]  i_gpio_oe,
    output logic      [4:0]  o_gpio_in,
    input  wire logic [4:0]  i_led_seg_drive,
    input  wire logic [3:0]  i_capcomp_out,
    input  wire logic [3:0]  i_capcomp_oe,
    output logic      [3:0]  o_capcomp_in,
    input  wire logic        i_i2c_master_scl_low,
    output logic             o_i2c_master_scl_in,
    input  wire logic        i_i2c_slave1_scl_low,
    output logic             o_i2c_slave1_scl_in,
    input  wire logic        i_i2c_slave2_scl_low,
    output logic             o_i2c_slave2_scl_in,
    input  wire logic        i_pwm_comp_out,
    output logic             o_spi_ssn_in,
    input  wire logic        i_spi_sck_out,
    input  wire logic        i_spi_sck_oe,
    output logic             o_spi_sck_in,
    output logic             o_timer2_trigger_in,
    output logic      [1:0]  o_pin_irq_group0,
    output logic      [1:0]  o_pin_irq_group1
);

    // ****************************************
    // Helpers
    // ****************************************

    // Maps a bus address to {hit, pin index}.
    function automatic logic [3:0] decode(input logic [15:0] addr);
        logic [3:0] res;
        res = 4'h0;
        case (addr)
            pin_function_pkg::OFS_P2_5: res = 4'h8;
            pin_function_pkg::OFS_P2_6: res = 4'h9;
            pin_function_pkg::OFS_P2_7: res = 4'hA;
            pin_function_pkg::OFS_P3_0: res = 4'hB;
            pin_function_pkg::OFS_P3_1: res = 4'hC;
            default:                    res = 4'h0;
        endcase
        return res;
    endfunction

    // Gives the writable bits of a register.
    function automatic logic [7:0] wmask(input logic [2:0] idx);
        logic [7:0] m;
        m = 8'h00;
        case (idx)
            3'd0:    m = pin_function_pkg::MASK_P2_5;
            3'd1:    m = pin_function_pkg::MASK_P2_6;
            3'd2:    m = pin_function_pkg::MASK_P2_7;
            3'd3:    m = pin_function_pkg::MASK_P3_0;
            3'd4:    m = pin_function_pkg::MASK_P3_1;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    // Configuration bytes and bus decode.
    logic [7:0] cfg_reg [pin_function_pkg::NUM_PINS];
    logic [3:0] wr_dec;
    logic [3:0] rd_dec;
    // Synchroniser stages and next pad drive.
    logic [4:0] sync_a_reg;
    logic [4:0] sync_b_reg;
    logic [4:0] pad_out_next;
    logic [4:0] pad_oe_next;
    // Per-pin views of the configuration.
    logic [7:0] p25;
    logic [7:0] p26;
    logic [7:0] p27;
    logic [7:0] p30;
    logic [7:0] p31;

    assign wr_dec = decode(i_reg_addr);
    assign rd_dec = decode(i_reg_addr);
    assign p25    = cfg_reg[pin_function_pkg::PIN_P2_5];
    assign p26    = cfg_reg[pin_function_pkg::PIN_P2_6];
    assign p27    = cfg_reg[pin_function_pkg::PIN_P2_7];
    assign p30    = cfg_reg[pin_function_pkg::PIN_P3_0];
    assign p31    = cfg_reg[pin_function_pkg::PIN_P3_1];

    // Stores masked write data; all registers clear at reset.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < pin_function_pkg::NUM_PINS; i++) begin
                cfg_reg[i] <= pin_function_pkg::RESET_VALUE;
            end
        end else if (i_clk_en && i_reg_wr && wr_dec[3]) begin
            cfg_reg[wr_dec[2:0]] <= i_reg_wdata & wmask(wr_dec[2:0]);
        end
    end

    // Read data stand in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= 8'h00;
        end else if (i_clk_en) begin
            if (i_reg_rd && rd_dec[3]) begin
                o_reg_rdata <= cfg_reg[rd_dec[2:0]] & wmask(rd_dec[2:0]);
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end

    // ****************************************
    // Pad input synchroniser
    // ****************************************

    // Two flops bring the pad levels into the clock domain.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_a_reg <= 5'h00;
            sync_b_reg <= 5'h00;
        end else if (i_clk_en) begin
            sync_a_reg <= i_pad_in;
            sync_b_reg <= sync_a_reg;
        end
    end

    // ****************************************
    // Pad output multiplexer
    // ****************************************

    // Fixed priority per pin: LED first, general I/O last.
    always_comb begin
        pad_out_next = 5'h00;
        pad_oe_next  = 5'h00;
        // Pin P2.5.
        if (p25[pin_function_pkg::BIT_LED_SEGMENT]) begin
            pad_out_next[0] = i_led_seg_drive[0];
            pad_oe_next[0]  = 1'b1;
        end else if (p25[pin_function_pkg::BIT_CAPCOMP_LINE]) begin
            pad_out_next[0] = i_capcomp_out[pin_function_pkg::CC_CH4];
            pad_oe_next[0]  = i_capcomp_oe[pin_function_pkg::CC_CH4];
        end else if (p25[pin_function_pkg::BIT_MASTER_I2C_CLOCK]) begin
            pad_oe_next[0]  = i_i2c_master_scl_low;
        end else if (p25[pin_function_pkg::BIT_SLAVE1_I2C_CLOCK]) begin
            pad_oe_next[0]  = i_i2c_slave1_scl_low;
        end else if (p25[pin_function_pkg::BIT_SLAVE2_I2C_CLOCK]) begin
            pad_oe_next[0]  = i_i2c_slave2_scl_low;
        end else if (PWM_COMP_ROUTE && p25[pin_function_pkg::BIT_COMPLEMENTARY_PWM]) begin
            pad_out_next[0] = i_pwm_comp_out;
            pad_oe_next[0]  = 1'b1;
        end else if (p25[pin_function_pkg::BIT_GENERAL_IO]) begin
            pad_out_next[0] = i_gpio_out[0];
            pad_oe_next[0]  = i_gpio_oe[0];
        end

        // Pin P2.6; slave select is an input and leaves the pad undriven.
        if (p26[pin_function_pkg::BIT_LED_SEGMENT]) begin
            pad_out_next[1] = i_led_seg_drive[1];
            pad_oe_next[1]  = 1'b1;
        end else if (p26[pin_function_pkg::BIT_CAPCOMP_LINE]) begin
            pad_out_next[1] = i_capcomp_out[pin_function_pkg::CC_CH5];
            pad_oe_next[1]  = i_capcomp_oe[pin_function_pkg::CC_CH5];
        end else if (!p26[pin_function_pkg::BIT_SPI_SLAVE_SELECT] && p26[pin_function_pkg::BIT_GENERAL_IO]) begin
            pad_out_next[1] = i_gpio_out[1];
            pad_oe_next[1]  = i_gpio_oe[1];
        end

        // Pin P2.7; the timer trigger is an input only.
        if (p27[pin_function_pkg::BIT_LED_SEGMENT]) begin
            pad_out_next[2] = i_led_seg_drive[2];
            pad_oe_next[2]  = 1'b1;
        end else if (p27[pin_function_pkg::BIT_TIMER2_TRIGGER]) begin
            pad_oe_next[2]  = 1'b0;
        end else if (p27[pin_function_pkg::BIT_SPI_CLOCK]) begin
            pad_out_next[2] = i_spi_sck_out;
            pad_oe_next[2]  = i_spi_sck_oe;
        end else if (p27[pin_function_pkg::BIT_GENERAL_IO]) begin
            pad_out_next[2] = i_gpio_out[2];
            pad_oe_next[2]  = i_gpio_oe[2];
        end

        // Pin P3.0.
        if (p30[pin_function_pkg::BIT_LED_SEGMENT]) begin
            pad_out_next[3] = i_led_seg_drive[3];
            pad_oe_next[3]  = 1'b1;
        end else if (p30[pin_function_pkg::BIT_CAPCOMP_LINE]) begin
            pad_out_next[3] = i_capcomp_out[pin_function_pkg::CC_CH2];
            pad_oe_next[3]  = i_capcomp_oe[pin_function_pkg::CC_CH2];
        end else if (p30[pin_function_pkg::BIT_GENERAL_IO]) begin
            pad_out_next[3] = i_gpio_out[3];
            pad_oe_next[3]  = i_gpio_oe[3];
        end

        // Pin P3.1.
        if (p31[pin_function_pkg::BIT_LED_SEGMENT]) begin
            pad_out_next[4] = i_led_seg_drive[4];
            pad_oe_next[4]  = 1'b1;
        end else if (p31[pin_function_pkg::BIT_CAPCOMP_LINE]) begin
            pad_out_next[4] = i_capcomp_out[pin_function_pkg::CC_CH3];
            pad_oe_next[4]  = i_capcomp_oe[pin_function_pkg::CC_CH3];
        end else if (p31[pin_function_pkg::BIT_GENERAL_IO]) begin
            pad_out_next[4] = i_gpio_out[4];
            pad_oe_next[4]  = i_gpio_oe[4];
        end
    end

    // Pad drive is registered so the pads see no decode glitches.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pad_out <= 5'h00;
            o_pad_oe  <= 5'h00;
        end else if (i_clk_en) begin
            o_pad_out <= pad_out_next;
            o_pad_oe  <= pad_oe_next;
        end
    end

    // ****************************************
    // Inputs towards the peripherals
    // ****************************************

    // An unselected input shows its idle level: I2C clocks and select high, every other input low.
    always_comb begin
        for (int i = 0; i < pin_function_pkg::NUM_PINS; i++) begin
            o_gpio_in[i] = sync_b_reg[i] & cfg_reg[i][pin_function_pkg::BIT_GENERAL_IO];
        end
        o_capcomp_in[pin_function_pkg::CC_CH4] = sync_b_reg[0] & p25[pin_function_pkg::BIT_CAPCOMP_LINE];
        o_capcomp_in[pin_function_pkg::CC_CH5] = sync_b_reg[1] & p26[pin_function_pkg::BIT_CAPCOMP_LINE];
        o_capcomp_in[pin_function_pkg::CC_CH2] = sync_b_reg[3] & p30[pin_function_pkg::BIT_CAPCOMP_LINE];
        o_capcomp_in[pin_function_pkg::CC_CH3] = sync_b_reg[4] & p31[pin_function_pkg::BIT_CAPCOMP_LINE];
        o_i2c_master_scl_in = sync_b_reg[0] | ~p25[pin_function_pkg::BIT_MASTER_I2C_CLOCK];
        o_i2c_slave1_scl_in = sync_b_reg[0] | ~p25[pin_function_pkg::BIT_SLAVE1_I2C_CLOCK];
        o_i2c_slave2_scl_in = sync_b_reg[0] | ~p25[pin_function_pkg::BIT_SLAVE2_I2C_CLOCK];
        o_spi_ssn_in        = sync_b_reg[1] | ~p26[pin_function_pkg::BIT_SPI_SLAVE_SELECT];
        o_spi_sck_in        = sync_b_reg[2] & p27[pin_function_pkg::BIT_SPI_CLOCK];
        o_timer2_trigger_in = sync_b_reg[2] & p27[pin_function_pkg::BIT_TIMER2_TRIGGER];
    end

    // Each group sees every selected pin; a pin may be in both groups.
    always_comb begin
        o_pin_irq_group0[0] = sync_b_reg[3] & p30[pin_function_pkg::BIT_PIN_IRQ_GROUP0];
        o_pin_irq_group0[1] = sync_b_reg[4] & p31[pin_function_pkg::BIT_PIN_IRQ_GROUP0];
        o_pin_irq_group1[0] = sync_b_reg[3] & p30[pin_function_pkg::BIT_PIN_IRQ_GROUP1];
        o_pin_irq_group1[1] = sync_b_reg[4] & p31[pin_function_pkg::BIT_PIN_IRQ_GROUP1];
    end

    // ****************************************
    // Assertions
    // ****************************************
    // All checks run on the system clock.
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    // Accesses to P2.5, used by the checks below.
    logic wr_p25;
    logic rd_p25;
    assign wr_p25 = i_clk_en && i_reg_wr && (i_reg_addr == pin_function_pkg::OFS_P2_5);
    assign rd_p25 = i_clk_en && i_reg_rd && (i_reg_addr == pin_function_pkg::OFS_P2_5);

    // A masked write reads back intact.
    a_write_readback: assert property (
        wr_p25 ##1 !(i_clk_en && i_reg_wr) ##1 rd_p25
            |=> o_reg_rdata == ($past(i_reg_wdata, 3) & pin_function_pkg::MASK_P2_5))
        else $error("P2.5 readback differs from masked write");

    // Unmapped reads return zero.
    a_unmapped_zero: assert property (
        i_clk_en && i_reg_rd && !rd_dec[3] |=> o_reg_rdata == 8'h00)
        else $error("Unmapped read not zero");

    // Segment 21 drive owns P2.5.
    a_led21_route: assert property (
        i_clk_en && p25[7] |=> o_pad_oe[0] && o_pad_out[0] == $past(i_led_seg_drive[0]))
        else $error("LED segment 21 not on P2.5");

    // Channel 4 enable reaches P2.5.
    a_capcomp4_route: assert property (
        i_clk_en && !p25[7] && p25[4] |=> o_pad_oe[0] == $past(i_capcomp_oe[2]))
        else $error("Channel 4 enable not on P2.5");

    // Master clock only pulls P2.5 low.
    a_master_scl_od: assert property (
        i_clk_en && p25[7:3] == 5'b00001 |=> !o_pad_out[0] && o_pad_oe[0] == $past(i_i2c_master_scl_low))
        else $error("Master clock not open drain on P2.5");

    // Slave select idles high when unused.
    a_ssn_idle_high: assert property (
        !p26[3] |-> o_spi_ssn_in)
        else $error("Slave select low while unselected");

    // A pin in both groups shows one level.
    a_irq_shared_pin: assert property (
        p30[1] && p30[2] |-> o_pin_irq_group0[0] == o_pin_irq_group1[0])
        else $error("Pin P3.0 differs between groups");

    // Group 0 is silent with no pin chosen.
    a_irq_gate_off: assert property (
        !p30[1] && !p31[1] |-> o_pin_irq_group0 == 2'b00)
        else $error("Group 0 active with no pin selected");

    // A low clock enable freezes state.
    a_freeze_hold: assert property (
        !i_clk_en |=> $stable(p25) && $stable(o_pad_oe))
        else $error("State changed with clock enable low");

    // Segment 20 drive owns P2.6.
    a_led20_route: assert property (
        i_clk_en && p26[7] |=> o_pad_oe[1] && o_pad_out[1] == $past(i_led_seg_drive[1]))
        else $error("LED segment 20 not on P2.6");

    // Channel 5 enable reaches P2.6.
    a_capcomp5_route: assert property (
        i_clk_en && !p26[7] && p26[4] |=> o_pad_oe[1] == $past(i_capcomp_oe[3]))
        else $error("Channel 5 enable not on P2.6");

    // Slave select leaves P2.6 undriven.
    a_ssn_no_drive: assert property (
        i_clk_en && p26[7:3] == 5'h01 |=> !o_pad_oe[1])
        else $error("P2.6 driven as slave select");

    // Segment 19 drive owns P2.7.
    a_led19_route: assert property (
        i_clk_en && p27[7] |=> o_pad_oe[2] && o_pad_out[2] == $past(i_led_seg_drive[2]))
        else $error("LED segment 19 not on P2.7");

    // The timer trigger leaves P2.7 undriven.
    a_trigger_no_drive: assert property (
        i_clk_en && !p27[7] && p27[4] |=> !o_pad_oe[2])
        else $error("P2.7 driven as timer trigger");

    // Serial clock drive reaches P2.7.
    a_sck_route: assert property (
        i_clk_en && p27[7:3] == 5'h01 |=> o_pad_oe[2] == $past(i_spi_sck_oe) && o_pad_out[2] == $past(i_spi_sck_out))
        else $error("SPI clock not on P2.7");

    // Complementary PWM owns P2.5 when no higher select is set.
    a_pwm_route: assert property (
        i_clk_en && PWM_COMP_ROUTE && p25[7:2] == 6'h08 |=> o_pad_oe[0] && o_pad_out[0] == $past(i_pwm_comp_out))
        else $error("PWM output not on P2.5");

    // Group 1 is silent with no pin chosen.
    a_irq1_gate_off: assert property (
        !p30[2] && !p31[2] |-> o_pin_irq_group1 == 2'b00)
        else $error("Group 1 active with no pin selected");

    // Main scenarios covered.
    c_led21_on: cover property (p25[7] ##1 o_pad_oe[0]);
    c_group0_two: cover property (p30[1] && p31[1]);
    c_both_groups: cover property (p30[1] && p30[2]);
    c_gpio_enabled: cover property (wr_p25 && i_reg_wdata[0]);
    c_pwm_selected: cover property (p25[5] && o_pad_oe[0]);

endmodule

// ### pad_world_model.sv
/*
 * Board side of pins P2.5 to P3.1: wires, pull-up and outside drivers.
 * Assumes the bench sets the outside drive and the device drives out/oe.
 */
`timescale 1ns/1ns
module pad_world_model (
    input  wire logic       i_sys_clk,
    input  wire logic [4:0] i_pad_out,
    input  wire logic [4:0] i_pad_oe,
    input  wire logic [4:0] i_ext_en,
    input  wire logic [4:0] i_ext_level,
    output logic      [4:0] o_pad_level
);
    logic [4:0] float_reg = 5'h0a;

    // Released pins without a pull-up toggle so a stale level never passes.
    always_ff @(posedge i_sys_clk) begin
        float_reg <= ~float_reg;
    end

    // P2.5 is an open-drain clock wire with a pull-up: wired AND of all parties.
    always_comb begin
        o_pad_level[0] = (i_pad_oe[0] ? i_pad_out[0] : 1'b1) & (i_ext_en[0] ? i_ext_level[0] : 1'b1);
        for (int k = 1; k < 5; k++) begin
            if (i_pad_oe[k]) begin
                o_pad_level[k] = i_pad_out[k];
            end else begin
                o_pad_level[k] = i_ext_en[k] ? i_ext_level[k] : float_reg[k];
            end
        end
    end
endmodule

// ### port2_port3_pin_function_select_bench.sv
/*
 * Self-checking bench for the pin function select block.
 * Assumes the pad model file is compiled first; one 25 MHz clock.
 */
`timescale 1ns/1ns
module port2_port3_pin_function_select_bench;
    logic        sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, pwm = 1'b0;
    logic [4:0]  pad_in, pad_out, pad_oe, gpio_in;
    logic [4:0]  gpio_out = 5'h00, gpio_oe = 5'h00, led = 5'h00, ext_en = 5'h00, ext_lvl = 5'h00;
    logic [3:0]  cc_out = 4'h0, cc_oe = 4'h0, cc_in;
    logic        m_low = 1'b0, s1_low = 1'b0, s2_low = 1'b0, sck_out = 1'b0, sck_oe = 1'b0;
    logic        m_in, s1_in, s2_in, ssn_in, sck_in, t2_in;
    logic [1:0]  irq0, irq1;
    int          n_mismatch = 0, cmp_count = 0;
    // Routing table: pin, register value, source kind, source index.
    localparam int N = 21;
    int          t_pin [N] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 4, 3, 4, 3, 4};
    logic [7:0]  t_val [N] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h80, 8'h10, 8'h08, 8'h01,
                               8'h80, 8'h10, 8'h08, 8'h01, 8'h10, 8'h10, 8'h80, 8'h80, 8'h01, 8'h01};
    int          t_src [N] = '{0, 4, 5, 1, 2, 3, 6, 0, 1, 7, 6, 0, 8, 9, 6, 1, 1, 0, 0, 6, 6};
    int          t_idx [N] = '{0, 0, 0, 2, 0, 0, 0, 1, 3, 0, 1, 2, 0, 0, 2, 0, 1, 3, 4, 3, 4};
    logic [7:0]  t_mask [5] = '{8'hfd, 8'h99, 8'h99, 8'h97, 8'h97};

    pin_function_select pin_function_select_i (
        .i_sys_clk(sys_clk), .i_rstn(rstn), .i_clk_en(clk_en), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .i_pad_in(pad_in), .o_pad_out(pad_out),
        .o_pad_oe(pad_oe), .i_gpio_out(gpio_out), .i_gpio_oe(gpio_oe), .o_gpio_in(gpio_in),
        .i_led_seg_drive(led), .i_capcomp_out(cc_out), .i_capcomp_oe(cc_oe), .o_capcomp_in(cc_in),
        .i_i2c_master_scl_low(m_low), .o_i2c_master_scl_in(m_in), .i_i2c_slave1_scl_low(s1_low),
        .o_i2c_slave1_scl_in(s1_in), .i_i2c_slave2_scl_low(s2_low), .o_i2c_slave2_scl_in(s2_in),
        .i_pwm_comp_out(pwm), .o_spi_ssn_in(ssn_in), .i_spi_sck_out(sck_out), .i_spi_sck_oe(sck_oe),
        .o_spi_sck_in(sck_in), .o_timer2_trigger_in(t2_in), .o_pin_irq_group0(irq0), .o_pin_irq_group1(irq1));

    pad_world_model pad_world_model_i (
        .i_sys_clk(sys_clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_ext_en(ext_en),
        .i_ext_level(ext_lvl), .o_pad_level(pad_in));

    // 25 MHz system clock.
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        cmp_byte(rdata, exp);
    endtask

    // Drives the chosen source to v and every other source to the opposite level; I2C pulls and output enables stay off when out_phase is low.
    task automatic drive(input int src, input int idx, input int pin, input logic v, input logic out_phase);
        led <= {5{~v}} ^ (src == 0 ? 5'h01 << idx : 5'h00);
        cc_out <= {4{~v}} ^ (src == 1 ? 4'h1 << idx : 4'h0);
        gpio_out <= {5{~v}} ^ (src == 6 ? 5'h01 << idx : 5'h00);
        pwm <= (src == 5) ? v : ~v;
        sck_out <= (src == 9) ? v : ~v;
        m_low <= out_phase & ((src == 2) ? v : ~v);
        s1_low <= out_phase & ((src == 3) ? v : ~v);
        s2_low <= out_phase & ((src == 4) ? v : ~v);
        cc_oe <= {4{out_phase}};
        gpio_oe <= {5{out_phase}};
        sck_oe <= out_phase;
        ext_en <= out_phase ? 5'h00 : 5'h01 << pin;
        ext_lvl <= {5{v}};
    endtask

    function automatic logic sel_in(input int src, input int idx);
        case (src)
            1: return cc_in[idx];
            2: return m_in;
            3: return s1_in;
            4: return s2_in;
            6: return gpio_in[idx];
            7: return ssn_in;
            8: return t2_in;
            default: return sck_in;
        endcase
    endfunction

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        logic v;
        logic eo;
        repeat (20) @(posedge sys_clk);
        cmp_bit(ssn_in, 1'b1);
        cmp_bit(m_in, 1'b1);
        cmp_byte({3'h0, pad_oe}, 8'h00);
        rstn <= 1'b1;
        for (int p = 0; p < 5; p++) begin
            bus_read(16'ha075 + 16'(p), 8'h00);
            bus_write(16'ha075 + 16'(p), 8'hff);
            bus_read(16'ha075 + 16'(p), t_mask[p]);
            bus_write(16'ha075 + 16'(p), 8'h00);
        end
        bus_write(16'ha075, 8'h21);
        bus_read(16'ha075, 8'h21);
        @(posedge sys_clk);
        #1;
        cmp_byte(rdata, 8'h00);
        bus_write(16'ha07a, 8'hff);
        bus_read(16'ha07a, 8'h00);
        bus_read(16'ha074, 8'h00);
        clk_en <= 1'b0;
        bus_write(16'ha076, 8'hff);
        clk_en <= 1'b1;
        bus_read(16'ha076, 8'h00);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        bus_read(16'ha075, 8'h00);
        $display("register test done");
        // Every function of every pin, both levels, out and in.
        for (int k = 0; k < N; k++) begin
            for (int b = 0; b < 2; b++) begin
                v = b[0];
                bus_write(16'ha075 + 16'(t_pin[k]), t_val[k]);
                drive(t_src[k], t_idx[k], t_pin[k], v, 1'b1);
                repeat (2) @(posedge sys_clk);
                #1;
                eo = (t_src[k] >= 2 && t_src[k] <= 4) ? v : (t_src[k] != 7 && t_src[k] != 8);
                cmp_bit(pad_oe[t_pin[k]], eo);
                if (eo) begin
                    cmp_bit(pad_out[t_pin[k]], (t_src[k] >= 2 && t_src[k] <= 4) ? 1'b0 : v);
                end
                drive(t_src[k], t_idx[k], t_pin[k], v, 1'b0);
                repeat (4) @(posedge sys_clk);
                #1;
                if (t_src[k] != 0 && t_src[k] != 5) begin
                    cmp_bit(sel_in(t_src[k], t_idx[k]), v);
                end
                bus_write(16'ha075 + 16'(t_pin[k]), 8'h00);
            end
        end
        $display("routing test done");
        // Interrupt group membership on P3.0 and P3.1.
        ext_en <= 5'h18;
        ext_lvl <= 5'h18;
        bus_write(16'ha078, 8'h06);
        bus_write(16'ha079, 8'h02);
        repeat (3) @(posedge sys_clk);
        #1;
        cmp_byte({6'h00, irq0}, 8'h03);
        cmp_byte({6'h00, irq1}, 8'h01);
        ext_lvl <= 5'h00;
        repeat (4) @(posedge sys_clk);
        #1;
        cmp_byte({4'h0, irq1, irq0}, 8'h00);
        ext_lvl <= 5'h18;
        bus_write(16'ha078, 8'h02);
        bus_write(16'ha079, 8'h04);
        repeat (3) @(posedge sys_clk);
        #1;
        cmp_byte({4'h0, irq1, irq0}, 8'h09);
        $display("interrupt group test done");
        report_and_stop();
    end

    // Watchdog: the tests need a few hundred cycles.
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
